// ---- verilog/isp_pkg.sv ----
// Purpose: Shared constants and types for the two-wire register port
// Assumes: 250 MHz core clock, 10-bit register pointer, 16-bit registers
// Notes: Both ends import this package whole
package isp_pkg;

  // ----------------------------------------
  // Clock and bus timing
  // ----------------------------------------
  // Core cycles per bus clock quarter; a fast bus keeps runs short
  localparam int ISP_SCL_QUARTER_CYC = 16;

  // ----------------------------------------
  // Addressing and data layout
  // ----------------------------------------
  localparam logic [4:0] ISP_DEV_ADDR_FIXED = 5'h0b;
  localparam logic ISP_DIR_WRITE = 1'b0;
  localparam logic ISP_DIR_READ = 1'b1;
  localparam int ISP_PTR_W = 10;
  localparam int ISP_DATA_W = 16;
  localparam logic [9:0] ISP_PTR_RESET = 10'h000;
  localparam logic [9:0] ISP_PTR_MAX = 10'h3ff;
  localparam logic [3:0] ISP_BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] ISP_BYTE_ADDR_HI = 2'h0;
  localparam logic [1:0] ISP_BYTE_ADDR_LO = 2'h1;
  localparam logic [1:0] ISP_BYTE_DATA_HI = 2'h2;
  localparam logic [1:0] ISP_BYTE_DATA_LO = 2'h3;

  // ----------------------------------------
  // Write buffer
  // ----------------------------------------
  localparam int ISP_FIFO_DEPTH = 16;
  localparam int ISP_FIFO_W = ISP_PTR_W + ISP_DATA_W;

  // ----------------------------------------
  // State and operation types
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE,
    ST_WR_ACK, ST_RD_BYTE, ST_RD_MACK} isp_dev_state_t;

  typedef enum logic [2:0] {OP_START, OP_TX, OP_RX_ACK, OP_RX_NACK, OP_STOP, OP_DONE} isp_host_op_t;

endpackage

// ---- verilog/isp_i2c_if.sv ----
// Purpose: Two-wire bus between the host end and the register port
// Assumes: Open-drain wires with pull-ups; an enable pulls the wire low
// Notes: The port never drives the clock wire
`timescale 1ns/1ns
interface isp_i2c_if;
  logic m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, s_sda_o, s_sda_oe, scl, sda;

  // ----------------------------------------
  // Wired-AND resolution
  // ----------------------------------------
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);

  modport slave (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

// ---- verilog/isp_slave_port.sv ----
// Purpose: Two-wire slave giving a bus master access to 16-bit registers
// Assumes: Register side answers a read request before the next bus clock fall
// Notes: Writes are queued in a 16-word buffer; a full buffer refuses the word
//
// How it works
// R1: Slave only; never starts or clocks transfers.
// R2: Answer 01011 plus two strap bits.
// R3: High strap is bit 1, low bit 0.
// R4: Shift in eight bits, MSB first.
// R5: Start is data falling while clock high.
// R6: Own address matched: acknowledge on ninth pulse.
// R7: Direction 0 writes, direction 1 reads.
// R8: Nine pulses per byte; acknowledge received bytes. Code nacks the lower data byte while the buffer is full, unless saturated.
// R9: Master changes data only while clock low.
// R10: Stop returns idle, pointer cleared to zero.
// R11: First write byte gives pointer bits 9:8.
// R12: Second write byte gives pointer bits 7:0.
// R13: Upper then lower data byte form word.
// R14: Pointer advances per word, saturates, then discards.
// R15: Master sends data bytes in pairs.
// R16: Master ends write with stop or restart.
// R17: Master sets pointer by write, then reads.
// R18: Read sends upper byte, then lower byte.
// R19: Pointer advances per read until master nacks.
// R20: At maximum pointer, keep resending last register.
// R21: Repeated start keeps the pointer.
`timescale 1ns/1ns

module isp_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [AW:0] count_q;
  wire push_w = in_valid_i && in_ready_o;
  wire pop_w = out_valid_o && out_ready_i;

  assign in_ready_o = (count_q != DEPTH[AW:0]);
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];

  always_ff @(posedge core_clk_i)
  begin
    if (push_w)
    begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push_w)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop_w)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};
    end
  end
endmodule

module isp_slave_port
  import isp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Bus side
  isp_i2c_if.slave bus,
  // Address straps
  input wire logic slave_addr_select_low_pin_i,
  input wire logic slave_addr_select_high_pin_i,
  // Register read request
  output logic reg_rd_req_o,
  output logic [ISP_PTR_W-1:0] reg_rd_addr_o,
  input wire logic reg_rd_valid_i,
  input wire logic [ISP_DATA_W-1:0] reg_rd_data_i,
  // Register write stream
  output logic reg_wr_valid_o,
  input wire logic reg_wr_ready_i,
  output logic [ISP_PTR_W-1:0] reg_wr_addr_o,
  output logic [ISP_DATA_W-1:0] reg_wr_data_o
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [3:0] pin_w;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic scl_prev_q, sda_prev_q;

  assign pin_w = {slave_addr_select_high_pin_i, slave_addr_select_low_pin_i, bus.sda, bus.scl};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge core_clk_i)
      begin
        if (srst_i)
        begin
          sync1_q[g] <= 1'b1;
          sync2_q[g] <= 1'b1;
        end
        else
        begin
          sync1_q[g] <= pin_w[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  wire scl_s_w = sync2_q[0];
  wire sda_s_w = sync2_q[1];

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s_w;
      sda_prev_q <= sda_s_w;
    end
  end

  // ----------------------------------------
  // Bus events and decode
  // ----------------------------------------
  // Only data edges with the clock high both before and after count
  wire start_w = scl_s_w && scl_prev_q && sda_prev_q && !sda_s_w; // see R5
  wire stop_w = scl_s_w && scl_prev_q && !sda_prev_q && sda_s_w; // see R10
  wire scl_rise_w = scl_s_w && !scl_prev_q;
  wire scl_fall_w = !scl_s_w && scl_prev_q;

  isp_dev_state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic [1:0] byte_idx_q;
  logic dir_q, half_q, mack_q, sat_q, sda_oe_q, rd_req_q, push_q;
  logic [ISP_FIFO_W-1:0] push_word_q;
  logic [ISP_PTR_W-1:0] ptr_q;
  logic [7:0] data_hi_q;
  logic [ISP_DATA_W-1:0] rd_word_q;
  logic fifo_in_ready_w;
  logic [ISP_FIFO_W-1:0] fifo_out_w;

  wire [6:0] own_addr_w = {ISP_DEV_ADDR_FIXED, sync2_q[3], sync2_q[2]}; // see R2, R3
  wire addr_match_w = (shift_q[7:1] == own_addr_w); // see R6
  wire at_max_w = (ptr_q == ISP_PTR_MAX);
  // Unless the pointer has saturated, a full buffer refuses the lower data byte with a not-acknowledge
  wire word_byte_w = (byte_idx_q == ISP_BYTE_DATA_LO);
  wire wr_ack_w = !(word_byte_w && !sat_q && !fifo_in_ready_w); // see R8
  wire [1:0] byte_idx_nx_w = word_byte_w ? ISP_BYTE_DATA_HI : byte_idx_q + 2'h1;
  wire send_lo_w = (state_q == ST_RD_MACK) && !half_q;
  wire [7:0] tx_byte_w = send_lo_w ? rd_word_q[7:0] : rd_word_q[15:8]; // see R18
  wire byte_done_w = scl_fall_w && (cnt_q == ISP_BITS_PER_BYTE);

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      byte_idx_q <= ISP_BYTE_ADDR_HI;
      dir_q <= ISP_DIR_WRITE;
      half_q <= 1'b0;
      mack_q <= 1'b0;
      sat_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rd_req_q <= 1'b0;
      push_q <= 1'b0;
      ptr_q <= ISP_PTR_RESET;
    end
    else
    begin
      rd_req_q <= 1'b0;
      push_q <= 1'b0;
      if (reg_rd_valid_i)
      begin
        rd_word_q <= reg_rd_data_i;
      end
      if (stop_w)
      begin
        state_q <= ST_IDLE; // see R10
        ptr_q <= ISP_PTR_RESET;
        sat_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end
      else if (start_w)
      begin
        // Pointer untouched so a read can follow a restart; see R21
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_ADDR, ST_WR_BYTE:
          begin
            if (scl_rise_w)
            begin
              shift_q <= {shift_q[6:0], sda_s_w}; // see R4, R9
              cnt_q <= cnt_q + 4'h1;
            end
            else if (byte_done_w && state_q == ST_ADDR)
            begin
              cnt_q <= 4'h0;
              if (addr_match_w)
              begin
                sda_oe_q <= 1'b1; // see R6
                dir_q <= shift_q[0]; // see R7
                half_q <= 1'b0;
                byte_idx_q <= ISP_BYTE_ADDR_HI;
                rd_req_q <= (shift_q[0] == ISP_DIR_READ);
                state_q <= ST_ADDR_ACK;
              end
              else
              begin
                state_q <= ST_IDLE;
              end
            end
            else if (byte_done_w)
            begin
              cnt_q <= 4'h0;
              sda_oe_q <= wr_ack_w; // see R8
              byte_idx_q <= byte_idx_nx_w;
              state_q <= ST_WR_ACK;
              case (byte_idx_q)
                ISP_BYTE_ADDR_HI:
                begin
                  ptr_q[9:8] <= shift_q[1:0]; // see R11
                  sat_q <= 1'b0;
                end
                ISP_BYTE_ADDR_LO:
                begin
                  ptr_q[7:0] <= shift_q; // see R12
                  sat_q <= 1'b0;
                end
                ISP_BYTE_DATA_HI:
                begin
                  data_hi_q <= shift_q;
                end
                default:
                begin
                  if (!sat_q && fifo_in_ready_w)
                  begin
                    push_q <= 1'b1;
                    push_word_q <= {ptr_q, data_hi_q, shift_q}; // see R13
                    if (at_max_w)
                    begin
                      sat_q <= 1'b1; // see R14
                    end
                    else
                    begin
                      ptr_q <= ptr_q + 10'h001;
                    end
                  end
                end
              endcase
            end
          end
          ST_ADDR_ACK, ST_WR_ACK:
          begin
            if (scl_fall_w && dir_q == ISP_DIR_READ)
            begin
              shift_q <= tx_byte_w;
              sda_oe_q <= !tx_byte_w[7];
              cnt_q <= 4'h0;
              state_q <= ST_RD_BYTE;
            end
            else if (scl_fall_w)
            begin
              sda_oe_q <= 1'b0;
              state_q <= ST_WR_BYTE;
            end
          end
          ST_RD_BYTE:
          begin
            if (scl_fall_w && cnt_q == 4'h7)
            begin
              sda_oe_q <= 1'b0;
              state_q <= ST_RD_MACK;
            end
            else if (scl_fall_w)
            begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_oe_q <= !shift_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
          ST_RD_MACK:
          begin
            if (scl_rise_w)
            begin
              mack_q <= !sda_s_w;
              if (!sda_s_w && half_q)
              begin
                rd_req_q <= 1'b1; // see R19, R20
                if (!at_max_w)
                begin
                  ptr_q <= ptr_q + 10'h001;
                end
              end
            end
            else if (scl_fall_w && !mack_q)
            begin
              state_q <= ST_IDLE; // see R19
            end
            else if (scl_fall_w)
            begin
              half_q <= !half_q;
              shift_q <= tx_byte_w;
              sda_oe_q <= !tx_byte_w[7];
              cnt_q <= 4'h0;
              state_q <= ST_RD_BYTE;
            end
          end
          default:
          begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Write buffer and outputs
  // ----------------------------------------
  isp_fifo #(
    .WIDTH(ISP_FIFO_W),
    .DEPTH(ISP_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .in_valid_i(push_q),
    .in_ready_o(fifo_in_ready_w),
    .in_data_i(push_word_q),
    .out_valid_o(reg_wr_valid_o),
    .out_ready_i(reg_wr_ready_i),
    .out_data_o(fifo_out_w)
  );

  assign reg_wr_addr_o = fifo_out_w[ISP_FIFO_W-1:ISP_DATA_W];
  assign reg_wr_data_o = fifo_out_w[ISP_DATA_W-1:0];
  assign reg_rd_req_o = rd_req_q;
  assign reg_rd_addr_o = ptr_q;
  // Open drain: only ever pulls low; clock wire is never driven (see R1)
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = sda_oe_q;
endmodule

// ---- verilog/isp_host_master.sv ----
// Purpose: Bus master issuing single-register writes and reads
// Assumes: One command at a time; slave never stretches the clock
// Notes: Read sets the pointer by write, then restarts and reads two bytes
`timescale 1ns/1ns
module isp_host_master
  import isp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Bus side
  isp_i2c_if.master bus,
  // Command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic [6:0] cmd_dev_addr_i,
  input wire logic [ISP_PTR_W-1:0] cmd_reg_addr_i,
  input wire logic [ISP_DATA_W-1:0] cmd_wdata_i,
  // Response
  output logic rsp_valid_o,
  output logic [ISP_DATA_W-1:0] rsp_rdata_o,
  output logic rsp_nack_o
);
  localparam logic [11:0] QUARTER_LAST = 12'(ISP_SCL_QUARTER_CYC - 1);

  logic sda_s1_q, sda_s2_q, busy_q, wr_q;
  logic [6:0] dev_q;
  logic [ISP_PTR_W-1:0] reg_q;
  logic [ISP_DATA_W-1:0] wdata_q;
  logic [11:0] div_q;
  logic [3:0] step_q, bit_q;
  logic [1:0] ph_q;
  logic [ISP_DATA_W-1:0] rx_q;
  logic nack_q, scl_oe_q, sda_oe_q, rsp_valid_q;
  isp_host_op_t op_w;
  logic [7:0] tx_w;

  // ----------------------------------------
  // Sequence decode
  // ----------------------------------------
  // Restart, not stop, keeps the pointer for the read (see R16, R17)
  always_comb
  begin
    op_w = OP_TX;
    tx_w = 8'h00;
    case (step_q)
      4'h0: op_w = OP_START;
      4'h1: tx_w = {dev_q, ISP_DIR_WRITE};
      4'h2: tx_w = {6'h00, reg_q[9:8]};
      4'h3: tx_w = reg_q[7:0];
      4'h4:
      begin
        op_w = wr_q ? OP_TX : OP_START;
        tx_w = wdata_q[15:8];
      end
      4'h5: tx_w = wr_q ? wdata_q[7:0] : {dev_q, ISP_DIR_READ}; // see R15
      4'h6: op_w = wr_q ? OP_STOP : OP_RX_ACK;
      4'h7: op_w = wr_q ? OP_DONE : OP_RX_NACK;
      4'h8: op_w = OP_STOP;
      default: op_w = OP_DONE;
    endcase
  end

  wire tick_w = (div_q == QUARTER_LAST);
  wire data_bit_w = !bit_q[3];
  wire tx_bit_w = tx_w[3'h7 - bit_q[2:0]];

  // ----------------------------------------
  // Bit engine
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      busy_q <= 1'b0;
      div_q <= 12'h000;
      step_q <= 4'h0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      rx_q <= '0;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rsp_valid_q <= 1'b0;
    end
    else
    begin
      sda_s1_q <= bus.sda;
      sda_s2_q <= sda_s1_q;
      rsp_valid_q <= 1'b0;
      div_q <= (tick_w || !busy_q) ? 12'h000 : div_q + 12'h001;
      if (!busy_q && cmd_valid_i)
      begin
        busy_q <= 1'b1;
        wr_q <= cmd_write_i;
        dev_q <= cmd_dev_addr_i;
        reg_q <= cmd_reg_addr_i;
        wdata_q <= cmd_wdata_i;
        step_q <= 4'h0;
        ph_q <= 2'h0;
        bit_q <= 4'h0;
        nack_q <= 1'b0;
      end
      else if (busy_q && tick_w)
      begin
        ph_q <= ph_q + 2'h1;
        case (op_w)
          OP_START:
          begin
            case (ph_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              default:
              begin
                scl_oe_q <= 1'b1;
                step_q <= step_q + 4'h1;
              end
            endcase
          end
          OP_STOP:
          begin
            case (ph_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b0;
              default: step_q <= step_q + 4'h1;
            endcase
          end
          OP_DONE:
          begin
            busy_q <= 1'b0;
            rsp_valid_q <= 1'b1;
          end
          default:
          begin
            case (ph_q)
              2'h0:
              begin
                // Data changes only with the clock low; see R9
                if (op_w == OP_TX)
                begin
                  sda_oe_q <= data_bit_w && !tx_bit_w;
                end
                else
                begin
                  sda_oe_q <= !data_bit_w && (op_w == OP_RX_ACK);
                end
              end
              2'h1: scl_oe_q <= 1'b0;
              2'h2:
              begin
                if (op_w == OP_TX && !data_bit_w && sda_s2_q)
                begin
                  nack_q <= 1'b1;
                end
                if (op_w != OP_TX && data_bit_w)
                begin
                  rx_q <= {rx_q[14:0], sda_s2_q};
                end
              end
              default:
              begin
                scl_oe_q <= 1'b1;
                bit_q <= data_bit_w ? bit_q + 4'h1 : 4'h0;
                if (!data_bit_w)
                begin
                  step_q <= step_q + 4'h1;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  assign cmd_ready_o = !busy_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_rdata_o = rx_q;
  assign rsp_nack_o = nack_q;
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_q;
endmodule

// ---- dv/isp_slave_port_props.sv ----
// Purpose: Wire-level checks of the register port on the host-joined bus
// Assumes: Straps held steady; host end clocks the bus
// Notes: Bit counter follows raw clock-wire rises
`timescale 1ns/1ns
module isp_slave_port_props
  import isp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe,
  // Straps
  input wire logic slave_addr_select_low_pin_i,
  input wire logic slave_addr_select_high_pin_i
);
  logic scl_q, sda_q, first_q, wr_q, rd_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  wire rise = scl && !scl_q;
  wire edge_cond = scl && scl_q && (sda != sda_q);
  wire nine = rise && (cnt_q == 4'h8);
  wire own = sh_q[7:1] == {ISP_DEV_ADDR_FIXED, slave_addr_select_high_pin_i, slave_addr_select_low_pin_i};

  // ----------------------------------------
  // Byte tracking
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    scl_q <= scl;
    sda_q <= sda;
    // Start or stop restarts framing
    if (srst_i || edge_cond)
    begin
      cnt_q <= 4'h0;
      first_q <= 1'b1;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else if (rise)
    begin
      cnt_q <= nine ? 4'h0 : cnt_q + 4'h1;
      sh_q <= {sh_q[6:0], sda};
      first_q <= first_q && !nine;
      wr_q <= (nine && first_q) ? own && !sh_q[0] : wr_q;
      rd_q <= (nine && first_q) ? own && sh_q[0] : rd_q;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence

  AST_SCL_HIGH_QUIET: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("port changed data wire while clock high");
  AST_START_QUIET: assert property (s_start |=> !s_sda_oe [*8])
    else $error("port drove data wire right after start");
  AST_STOP_IDLE: assert property (s_stop |=> !s_sda_oe [*8])
    else $error("port drove data wire after stop");
  AST_NO_FOREIGN: assert property (nine && first_q && sh_q[7:3] != ISP_DEV_ADDR_FIXED |-> sda)
    else $error("port acknowledged a foreign address");
  AST_ACK_OWN: assert property (nine && first_q && own |-> !sda)
    else $error("port missed its own address");
  AST_WR_ACK: assert property (nine && !first_q && wr_q |-> !sda)
    else $error("written byte not acknowledged");
  AST_WR_LISTEN: assert property (rise && cnt_q < 4'h8 && !first_q && wr_q |-> !s_sda_oe)
    else $error("port drove data wire during a write byte");
  AST_RD_MACK: assert property (nine && !first_q && rd_q |-> !s_sda_oe)
    else $error("port drove data wire in master ack slot");
endmodule

// ---- dv/i2c_slave_register_port_test.sv ----
// Purpose: Self-checking bench for the host end and register port
// Assumes: Bus a joins both design ends; bus b has a bench master at the host end's bus rate
// Notes: Port a high strap is driven, not tied
`timescale 1ns/1ns
module i2c_slave_register_port_test
  import isp_pkg::*;
  ;
  localparam int BQ = 16;
  logic clk, srst, cv, cw, crdy, rv, rnk, strap_hi;
  logic [6:0] cdev;
  logic [9:0] creg;
  logic [15:0] cwd, rrd;
  wire [1:0] rq, wv;
  wire [9:0] ra [2], wa [2];
  wire [15:0] wd [2];
  logic [1:0] rvl, wrdy;
  logic [15:0] rdat [2];
  logic [25:0] wq [$];
  int n_mismatch = 0;
  int compares = 0;

  isp_i2c_if i_isp_i2c_if();
  isp_i2c_if i_isp_i2c_if_b();
  isp_host_master i_isp_host_master (.core_clk_i(clk), .srst_i(srst), .bus(i_isp_i2c_if.master),
    .cmd_valid_i(cv), .cmd_ready_o(crdy), .cmd_write_i(cw), .cmd_dev_addr_i(cdev), .cmd_reg_addr_i(creg),
    .cmd_wdata_i(cwd), .rsp_valid_o(rv), .rsp_rdata_o(rrd), .rsp_nack_o(rnk));
  isp_slave_port i_isp_slave_port (.core_clk_i(clk), .srst_i(srst), .bus(i_isp_i2c_if.slave),
    .slave_addr_select_low_pin_i(1'b0), .slave_addr_select_high_pin_i(strap_hi),
    .reg_rd_req_o(rq[0]), .reg_rd_addr_o(ra[0]), .reg_rd_valid_i(rvl[0]), .reg_rd_data_i(rdat[0]),
    .reg_wr_valid_o(wv[0]), .reg_wr_ready_i(wrdy[0]), .reg_wr_addr_o(wa[0]), .reg_wr_data_o(wd[0]));
  isp_slave_port i_isp_slave_port_b (.core_clk_i(clk), .srst_i(srst), .bus(i_isp_i2c_if_b.slave),
    .slave_addr_select_low_pin_i(1'b0), .slave_addr_select_high_pin_i(1'b0),
    .reg_rd_req_o(rq[1]), .reg_rd_addr_o(ra[1]), .reg_rd_valid_i(rvl[1]), .reg_rd_data_i(rdat[1]),
    .reg_wr_valid_o(wv[1]), .reg_wr_ready_i(wrdy[1]), .reg_wr_addr_o(wa[1]), .reg_wr_data_o(wd[1]));
  isp_slave_port_props i_props (.core_clk_i(clk), .srst_i(srst), .scl(i_isp_i2c_if.scl),
    .sda(i_isp_i2c_if.sda), .s_sda_oe(i_isp_i2c_if.s_sda_oe), .slave_addr_select_low_pin_i(1'b0),
    .slave_addr_select_high_pin_i(strap_hi));

  // ----------------------------------------
  // Register side model
  // ----------------------------------------
  function automatic logic [15:0] rf(input logic [9:0] a);
    rf = {6'h2b, a};
  endfunction

  // Answers one cycle after each request
  always @(posedge clk)
  begin
    rvl <= rq;
    rdat[0] <= rf(ra[0]);
    rdat[1] <= rf(ra[1]);
    for (int i = 0; i < 2; i++)
      if (wv[i] && wrdy[i])
        wq.push_back({wa[i], wd[i]});
  end

  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wchk(input logic [25:0] exp);
    chk(wq.size() > 0 ? wq.pop_front() : '1, exp);
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic host(input logic w, input logic [6:0] d, input logic [9:0] a, input logic [15:0] v);
    cw = w;
    cdev = d;
    creg = a;
    cwd = v;
    cv = 1'b1;
    @(negedge clk);
    cv = 1'b0;
    while (rv !== 1'b1)
      @(negedge clk);
  endtask

  task automatic bb_set(input bit c, input logic v);
    if (c)
      i_isp_i2c_if_b.m_scl_oe = v;
    else
      i_isp_i2c_if_b.m_sda_oe = v;
    repeat (BQ) @(negedge clk);
  endtask

  task automatic bb_bit(input logic d, output logic s);
    bb_set(1'b0, !d);
    bb_set(1'b1, 1'b0);
    s = i_isp_i2c_if_b.sda;
    bb_set(1'b1, 1'b0);
    bb_set(1'b1, 1'b1);
  endtask

  // Also serves as repeated start after an ack slot
  task automatic bb_start();
    bb_set(1'b0, 1'b0);
    bb_set(1'b1, 1'b0);
    bb_set(1'b0, 1'b1);
    bb_set(1'b1, 1'b1);
  endtask

  task automatic bb_stop();
    bb_set(1'b0, 1'b1);
    bb_set(1'b1, 1'b0);
    bb_set(1'b0, 1'b0);
  endtask

  task automatic bb_byte(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bb_bit(d[i], b);
      r = {r[6:0], b};
    end
    bb_bit(a, k);
  endtask

  task automatic bb_wr(input logic [7:0] d, input logic e);
    logic [7:0] r;
    logic k;
    bb_byte(d, 1'b1, r, k);
    chk(k, e);
  endtask

  task automatic bb_rd(input logic nack, input logic [15:0] e);
    logic [7:0] h;
    logic [7:0] l;
    logic k;
    bb_byte(8'hff, 1'b0, h, k);
    bb_byte(8'hff, nack, l, k);
    chk({h, l}, e);
  endtask

  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end

  initial
  begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    srst = 1'b1;
    cv = 1'b0;
    cw = 1'b0;
    cdev = 7'h00;
    creg = 10'h000;
    cwd = 16'h0000;
    strap_hi = 1'b1;
    wrdy = 2'h3;
    i_isp_i2c_if_b.m_scl_o = 1'b0;
    i_isp_i2c_if_b.m_sda_o = 1'b0;
    i_isp_i2c_if_b.m_scl_oe = 1'b0;
    i_isp_i2c_if_b.m_sda_oe = 1'b0;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    // Host end: own address, then foreign ones
    host(1'b1, 7'h2e, 10'h2a5, 16'hbeef);
    chk(rnk, 1'b0);
    wchk({10'h2a5, 16'hbeef});
    host(1'b0, 7'h2e, 10'h2a5, 16'h0000);
    chk(rrd, rf(10'h2a5));
    host(1'b1, 7'h0e, 10'h001, 16'h1234);
    chk(rnk, 1'b1);
    host(1'b1, 7'h2d, 10'h001, 16'h1234);
    chk(rnk, 1'b1);
    chk(26'(wq.size()), 26'h0);
    // Bus b, port at 7'h2c: saturation
    bb_start();
    bb_wr(8'h58, 1'b0);
    bb_wr(8'hff, 1'b0);
    bb_wr(8'hfe, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      bb_wr(8'ha0 + 8'(k), 1'b0);
      bb_wr(8'h50 + 8'(k), 1'b0);
    end
    bb_stop();
    repeat (8) @(negedge clk);
    wchk({10'h3fe, 16'ha050});
    wchk({10'h3ff, 16'ha151});
    chk(26'(wq.size()), 26'h0);
    // Pointer by write, restart, read past the top
    bb_start();
    bb_wr(8'h58, 1'b0);
    bb_wr(8'h03, 1'b0);
    bb_wr(8'hfe, 1'b0);
    bb_start();
    bb_wr(8'h59, 1'b0);
    bb_rd(1'b0, rf(10'h3fe));
    bb_rd(1'b0, rf(10'h3ff));
    bb_rd(1'b1, rf(10'h3ff));
    bb_stop();
    // Stop cleared the pointer
    bb_start();
    bb_wr(8'h59, 1'b0);
    bb_rd(1'b1, rf(10'h000));
    bb_stop();
    // Stall: seventeenth word refused
    wrdy[1] = 1'b0;
    bb_start();
    bb_wr(8'h58, 1'b0);
    bb_wr(8'h00, 1'b0);
    bb_wr(8'h10, 1'b0);
    for (int k = 0; k < 17; k++)
    begin
      bb_wr(8'(k), 1'b0);
      bb_wr(8'hc0, k == 16);
    end
    bb_stop();
    wrdy[1] = 1'b1;
    repeat (40) @(negedge clk);
    for (int k = 0; k < 16; k++)
      wchk({10'h010 + 10'(k), 8'(k), 8'hc0});
    chk(26'(wq.size()), 26'h0);
    finish_test();
  end
endmodule
